// [bmc_defs.svh]
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define BMC_CLK_HZ 100000000
`define BMC_SEC_MS 1000
`define BMC_DEB_MS 20
`define BMC_BLINK_MS 250

// ----------------------------------------------------------------------
// Menu slot boundaries in whole seconds of hold (first second, last + 1)
// ----------------------------------------------------------------------
`define BMC_S_REG_LO 7'h03
`define BMC_S_REG_HI 7'h0f
`define BMC_S_DEL_LO 7'h10
`define BMC_S_DEL_HI 7'h1c
`define BMC_S_RA_LO 7'h1d
`define BMC_S_RA_HI 7'h20
`define BMC_S_RB_LO 7'h21
`define BMC_S_RB_HI 7'h24
`define BMC_S_RC_LO 7'h25
`define BMC_S_RC_HI 7'h28
`define BMC_S_RD_HI 7'h2b
`define BMC_S_CAL_HI 7'h31
`define BMC_S_CAL2_LO 7'h32
`define BMC_S_CAL2_HI 7'h38
`define BMC_S_ERA_HI 7'h3b
`define BMC_S_ANG0_HI 7'h3f
`define BMC_S_ANG1_HI 7'h42
`define BMC_S_SPR_LO 7'h43
`define BMC_S_SPR_HI 7'h46
`define BMC_S_END 7'h47
`define BMC_SLOT_LEN 7'h03

// ----------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------
`define BMC_A_STATUS 8'h00
`define BMC_A_CONFIG 8'h04
`define BMC_A_CTRL 8'h08
`define BMC_A_IRQ_STAT 8'h0c
`define BMC_A_IRQ_MASK 8'h10
`define BMC_IRQ_W 3
`define BMC_IRQ_COMMIT 0
`define BMC_IRQ_END 1
`define BMC_IRQ_REGD 2
`define BMC_CTRL_LOCK 0

// ----------------------------------------------------------------------
// Settings store: two words, each tagged with a validity marker
// ----------------------------------------------------------------------
`define BMC_MARK 4'ha
`define BMC_W_CFG 1'h0
`define BMC_W_ONL 1'h1

`endif

// [bmc_menu.sv]
// The implementer's own choices: the strobed register port and the placing of the registers.
`include "bmc_defs.svh"

module bmc_menu
  import bmc_pkg::*;
#(
  parameter int SEC_CYC = `BMC_CLK_HZ / 1000 * `BMC_SEC_MS,
  parameter int DEB_CYC = `BMC_CLK_HZ / 1000 * `BMC_DEB_MS,
  parameter int BLINK_CYC = `BMC_CLK_HZ / 1000 * `BMC_BLINK_MS
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic btn_n,
  input wire bmc_chan_t chan,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_ff,
  output logic irq_ff,
  output logic [3:0] led_green_ff,
  output logic [3:0] led_yellow_ff,
  output bmc_cmd_t cmd_ff,
  output bmc_range_t range_ff,
  output logic voltage_ff,
  output logic angle_ff
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  bmc_state_t st_ff, nxt_st;
  bmc_cfg_t cfg_ff, nxt_cfg;
  bmc_slot_t cur_slot;
  logic btn_m_ff, btn_s_ff, btn_ff;
  logic [31:0] deb_cnt_ff, sec_cnt_ff, blink_cnt_ff;
  logic blink_ff;
  logic [6:0] sec_ff;
  logic [3:0] pend_ff;
  logic save_cfg_ff, save_onl_ff;
  logic lock_ff, onl_load_ff;
  logic [`BMC_IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_ev;
  logic release_ev, commit, store_we, store_addr;
  logic [7:0] store_wdata, store_rdata;

  // Decodes the hold time into the function slot it stands in.
  function automatic bmc_slot_t bmc_slot(input logic [6:0] s);
    bmc_slot_t r;
    r.fn = FN_NONE;
    r.ch = 2'h0;
    r.rng = RNG_A;
    if (s >= `BMC_S_REG_LO && s < `BMC_S_REG_HI)
    begin
      r.fn = FN_REG;
      r.ch = 2'((s - `BMC_S_REG_LO) / `BMC_SLOT_LEN);
    end
    else if (s >= `BMC_S_DEL_LO && s < `BMC_S_DEL_HI)
    begin
      r.fn = FN_DEL;
      r.ch = 2'((s - `BMC_S_DEL_LO) / `BMC_SLOT_LEN);
    end
    else if (s >= `BMC_S_RA_LO && s < `BMC_S_RA_HI)
    begin
      r.fn = FN_RNG;
    end
    else if (s >= `BMC_S_RB_LO && s < `BMC_S_RB_HI)
    begin
      r.fn = FN_RNG;
      r.rng = RNG_B;
    end
    else if (s >= `BMC_S_RC_LO && s < `BMC_S_RC_HI)
    begin
      r.fn = FN_RNG;
      r.rng = RNG_C;
    end
    else if (s >= `BMC_S_RC_HI && s < `BMC_S_RD_HI)
    begin
      r.fn = FN_RNG;
      r.rng = RNG_D;
    end
    else if (s >= `BMC_S_RD_HI && s < `BMC_S_CAL_HI)
    begin
      r.fn = FN_CAL;
      r.ch = 2'((s - `BMC_S_RD_HI) / `BMC_SLOT_LEN);
    end
    else if (s >= `BMC_S_CAL2_LO && s < `BMC_S_CAL2_HI)
    begin
      r.fn = FN_CAL;
      r.ch = 2'(7'h02 + (s - `BMC_S_CAL2_LO) / `BMC_SLOT_LEN);
    end
    else if (s >= `BMC_S_CAL2_HI && s < `BMC_S_ERA_HI)
    begin
      r.fn = FN_ERASE;
    end
    else if (s >= `BMC_S_ERA_HI && s < `BMC_S_ANG1_HI)
    begin
      r.fn = FN_ANGLE;
      r.ch = (s < `BMC_S_ANG0_HI) ? 2'h1 : 2'h2;
    end
    else if (s >= `BMC_S_SPR_LO && s < `BMC_S_SPR_HI)
    begin
      r.fn = FN_SPARE;
      r.ch = 2'h3;
    end
    else if (s >= `BMC_S_END)
    begin
      r.fn = FN_END;
    end
    return r;
  endfunction

  assign cur_slot = bmc_slot(sec_ff);

  // ----------------------------------------------------------------------
  // Button synchroniser and debouncer
  // ----------------------------------------------------------------------
  // Level changes only after DEB_CYC stable cycles, so contact bounce never
  // starts or commits a selection.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      btn_m_ff <= 1'b0;
      btn_s_ff <= 1'b0;
      btn_ff <= 1'b0;
      deb_cnt_ff <= 32'h0;
    end
    else
    begin
      btn_m_ff <= ~btn_n;
      btn_s_ff <= btn_m_ff;
      if (btn_s_ff == btn_ff)
      begin
        deb_cnt_ff <= 32'h0;
      end
      else if (deb_cnt_ff >= 32'(DEB_CYC - 1))
      begin
        btn_ff <= btn_s_ff;
        deb_cnt_ff <= 32'h0;
      end
      else
      begin
        deb_cnt_ff <= deb_cnt_ff + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Hold timer and blink divider
  // ----------------------------------------------------------------------
  // Seconds count from the press; entering the end state clears the count.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sec_cnt_ff <= 32'h0;
      sec_ff <= 7'h00;
    end
    else if (st_ff != ST_HOLD)
    begin
      sec_cnt_ff <= 32'h0;
      sec_ff <= 7'h00;
    end
    else if (sec_cnt_ff >= 32'(SEC_CYC - 1))
    begin
      sec_cnt_ff <= 32'h0;
      sec_ff <= sec_ff + 7'h01;
    end
    else
    begin
      sec_cnt_ff <= sec_cnt_ff + 32'h1;
    end
  end

  // Free-running blink phase shared by menu and status display.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      blink_cnt_ff <= 32'h0;
      blink_ff <= 1'b0;
    end
    else if (blink_cnt_ff >= 32'(BLINK_CYC - 1))
    begin
      blink_cnt_ff <= 32'h0;
      blink_ff <= ~blink_ff;
    end
    else
    begin
      blink_cnt_ff <= blink_cnt_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Menu state machine
  // ----------------------------------------------------------------------
  assign release_ev = (st_ff == ST_HOLD) && !btn_ff;
  // Releasing in a gap, the spare slot or the end slot selects nothing.
  assign commit = release_ev && (cur_slot.fn != FN_END) && (cur_slot.fn != FN_NONE)
    && (cur_slot.fn != FN_SPARE);

  // Reset reads the store back, so a power cut also leaves programming.
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_LOAD0: nxt_st = ST_LOAD1;
      ST_LOAD1: nxt_st = ST_IDLE;
      ST_IDLE: if (btn_ff && !lock_ff) nxt_st = ST_HOLD;
      ST_HOLD:
      begin
        if (!btn_ff)
        begin
          nxt_st = ST_IDLE;
        end
        else if (cur_slot.fn == FN_END)
        begin
          nxt_st = ST_END;
        end
      end
      ST_END: if (!btn_ff) nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= ST_LOAD0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------------
  // Stored words without the marker fall back to the factory setting.
  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (st_ff == ST_LOAD1 && store_rdata[7:4] == `BMC_MARK)
    begin
      nxt_cfg.rng = bmc_range_t'(store_rdata[2:1]);
      nxt_cfg.angle = store_rdata[0];
    end
    else if (onl_load_ff && store_rdata[7:4] == `BMC_MARK)
    begin
      nxt_cfg.online = store_rdata[3:0];
    end
    if (commit)
    begin
      case (cur_slot.fn)
        FN_DEL: nxt_cfg.online[cur_slot.ch] = 1'b0;
        FN_RNG: nxt_cfg.rng = cur_slot.rng;
        FN_ANGLE: nxt_cfg.angle = (cur_slot.ch == 2'h2);
        FN_ERASE:
        begin
          nxt_cfg.rng = RNG_B;
          nxt_cfg.angle = 1'b0;
          nxt_cfg.online = 4'h0;
        end
        default: nxt_cfg.online = nxt_cfg.online | (chan.reg_done & pend_ff);
      endcase
    end
    else
    begin
      nxt_cfg.online = nxt_cfg.online | (chan.reg_done & pend_ff);
    end
  end

  // Online mask is read in the cycle after the config word.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_ff <= '{rng: RNG_B, angle: 1'b0, online: 4'h0};
      onl_load_ff <= 1'b0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      onl_load_ff <= (st_ff == ST_LOAD1);
    end
  end

  // Pending registrations; a new press of the same slot restarts it.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_ff <= 4'h0;
    end
    else if (commit && cur_slot.fn == FN_ERASE)
    begin
      pend_ff <= 4'h0;
    end
    else
    begin
      pend_ff <= (pend_ff & ~chan.reg_done)
        | ((commit && cur_slot.fn == FN_REG) ? (4'h1 << cur_slot.ch) : 4'h0);
    end
  end

  // Any change is written back; config word has priority over the mask.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      save_cfg_ff <= 1'b0;
      save_onl_ff <= 1'b0;
    end
    else if (st_ff != ST_LOAD0 && st_ff != ST_LOAD1)
    begin
      save_cfg_ff <= (nxt_cfg.rng != cfg_ff.rng) || (nxt_cfg.angle != cfg_ff.angle)
        || (commit && cur_slot.fn == FN_ERASE) || (save_cfg_ff && 1'b0);
      save_onl_ff <= (nxt_cfg.online != cfg_ff.online) || (save_onl_ff && save_cfg_ff)
        || (commit && cur_slot.fn == FN_ERASE);
    end
  end

  assign store_we = save_cfg_ff || save_onl_ff;
  assign store_addr = (st_ff == ST_LOAD0) ? `BMC_W_CFG
    : (st_ff == ST_LOAD1) ? `BMC_W_ONL
    : save_cfg_ff ? `BMC_W_CFG : `BMC_W_ONL;
  assign store_wdata = save_cfg_ff ? {`BMC_MARK, 1'b0, cfg_ff.rng, cfg_ff.angle}
    : {`BMC_MARK, cfg_ff.online};

  bmc_store u_store (
    .core_clk(core_clk),
    .rstn(rstn),
    .we(store_we),
    .addr(store_addr),
    .wdata(store_wdata),
    .rdata_ff(store_rdata)
  );

  // ----------------------------------------------------------------------
  // Outputs: LEDs, requests, output type
  // ----------------------------------------------------------------------
  // Menu display while held, all lamps dark in the end state, channel status otherwise.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      led_green_ff <= 4'h0;
      led_yellow_ff <= 4'h0;
    end
    else if (st_ff == ST_HOLD)
    begin
      led_green_ff <= 4'h0;
      led_yellow_ff <= 4'h0;
      case (cur_slot.fn)
        FN_REG: led_green_ff <= {3'h0, blink_ff} << cur_slot.ch;
        FN_DEL: led_green_ff <= 4'h1 << cur_slot.ch;
        FN_RNG:
        begin
          if (cur_slot.rng == RNG_A || cur_slot.rng == RNG_B)
          begin
            led_green_ff <= (cur_slot.rng == RNG_A) ? {4{blink_ff}} : 4'hf;
          end
          else
          begin
            led_yellow_ff <= (cur_slot.rng == RNG_C) ? {4{blink_ff}} : 4'hf;
          end
        end
        FN_CAL:
        begin
          led_green_ff <= {3'h0, blink_ff} << cur_slot.ch;
          led_yellow_ff <= {3'h0, blink_ff} << cur_slot.ch;
        end
        FN_ERASE, FN_ANGLE, FN_SPARE: led_yellow_ff <= {3'h0, blink_ff} << cur_slot.ch;
        default: led_green_ff <= 4'h0;
      endcase
    end
    else if (st_ff == ST_END)
    begin
      led_green_ff <= 4'h0;
      led_yellow_ff <= 4'h0;
    end
    else
    begin
      led_green_ff <= (cfg_ff.online & ~chan.sleep & ~chan.lost)
        | ({4{blink_ff}} & (pend_ff | (cfg_ff.online & (chan.sleep | chan.lost))));
      led_yellow_ff <= chan.low_batt & cfg_ff.online;
    end
  end

  // One-cycle requests issued on the release that commits them.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_ff <= '0;
    end
    else
    begin
      cmd_ff.reg_start <= (commit && cur_slot.fn == FN_REG) ? (4'h1 << cur_slot.ch) : 4'h0;
      cmd_ff.del <= (commit && cur_slot.fn == FN_DEL) ? (4'h1 << cur_slot.ch) : 4'h0;
      cmd_ff.cal <= (commit && cur_slot.fn == FN_CAL) ? (4'h1 << cur_slot.ch) : 4'h0;
      cmd_ff.erase <= commit && cur_slot.fn == FN_ERASE;
    end
  end

  // The one range field drives both range_ff and voltage_ff, so a mix cannot arise.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      range_ff <= RNG_B;
      voltage_ff <= 1'b0;
      angle_ff <= 1'b0;
    end
    else
    begin
      range_ff <= cfg_ff.rng;
      voltage_ff <= (cfg_ff.rng != RNG_B);
      angle_ff <= cfg_ff.angle;
    end
  end

  // ----------------------------------------------------------------------
  // Register port and interrupt
  // ----------------------------------------------------------------------
  // The end slot is left from its own state, so its release is seen there.
  assign irq_ev = {|(chan.reg_done & pend_ff),
    (release_ev && cur_slot.fn == FN_END) || (st_ff == ST_END && !btn_ff), commit};

  // Hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      lock_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~((wr && addr == `BMC_A_IRQ_STAT)
        ? wdata[`BMC_IRQ_W-1:0] : '0)) | irq_ev;
      if (wr && addr == `BMC_A_IRQ_MASK)
      begin
        irq_mask_ff <= wdata[`BMC_IRQ_W-1:0];
      end
      if (wr && addr == `BMC_A_CTRL)
      begin
        lock_ff <= wdata[`BMC_CTRL_LOCK];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_ff <= 32'h0;
    end
    else if (!rd)
    begin
      rdata_ff <= 32'h0;
    end
    else if (addr == `BMC_A_STATUS)
    begin
      rdata_ff <= {17'h0, sec_ff, 4'h0, cur_slot.fn[3:0] == FN_END, st_ff == ST_END,
        btn_ff, st_ff == ST_HOLD};
    end
    else if (addr == `BMC_A_CONFIG)
    begin
      rdata_ff <= {20'h0, pend_ff, cfg_ff.online, cfg_ff.angle, cfg_ff.rng != RNG_B, cfg_ff.rng};
    end
    else if (addr == `BMC_A_CTRL)
    begin
      rdata_ff <= {31'h0, lock_ff};
    end
    else if (addr == `BMC_A_IRQ_STAT)
    begin
      rdata_ff <= {29'h0, irq_stat_ff};
    end
    else if (addr == `BMC_A_IRQ_MASK)
    begin
      rdata_ff <= {29'h0, irq_mask_ff};
    end
    else
    begin
      rdata_ff <= 32'h0;
    end
  end

endmodule

// [bmc_menu_op.sv]
// ----------------------------------------------------------------------
// Operator at the button and the sensors on the radio side
// ----------------------------------------------------------------------
module bmc_menu_op
  import bmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [15:0] hold_cyc,
  input wire logic [11:0] stat,
  input wire bmc_cmd_t cmd,
  output logic btn_n,
  output logic busy,
  output bmc_chan_t chan
);
  logic [15:0] cnt_ff;
  logic [3:0] d1_ff;
  logic [3:0] d2_ff;

  // The operator holds the button for the asked time, then lets go.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      btn_n <= 1'h1;
      busy <= 1'h0;
      cnt_ff <= 16'h0;
    end
    else if (go)
    begin
      btn_n <= 1'h0;
      busy <= 1'h1;
      cnt_ff <= hold_cyc;
    end
    else if (cnt_ff != 16'h0)
      cnt_ff <= cnt_ff - 16'h1;
    else
    begin
      btn_n <= 1'h1;
      busy <= 1'h0;
    end
  end

  // A sensor answers a registration request two cycles later, never sooner.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      d1_ff <= 4'h0;
      d2_ff <= 4'h0;
    end
    else
    begin
      d1_ff <= cmd.reg_start;
      d2_ff <= d1_ff;
    end
  end
  assign chan = '{sleep: stat[11:8], lost: stat[7:4], low_batt: stat[3:0], reg_done: d2_ff};
endmodule

// [bmc_menu_sva.sv]
// ----------------------------------------------------------------------
// Port checker for the button menu controller
// ----------------------------------------------------------------------
module bmc_menu_sva
  import bmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic btn_n,
  input wire bmc_chan_t chan,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata_ff,
  input wire logic irq_ff,
  input wire logic [3:0] led_green_ff,
  input wire logic [3:0] led_yellow_ff,
  input wire bmc_cmd_t cmd_ff,
  input wire bmc_range_t range_ff,
  input wire logic voltage_ff,
  input wire logic angle_ff
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_type_shared: assert property (voltage_ff == (range_ff != RNG_B))
    else $error("output type does not follow the range");
  chk_reg_onehot: assert property ($onehot0(cmd_ff.reg_start))
    else $error("more than one registration request");
  chk_del_onehot: assert property ($onehot0(cmd_ff.del))
    else $error("more than one delete request");
  chk_cmd_single: assert property ((|cmd_ff) |=> (cmd_ff == '0))
    else $error("command pulse longer than one cycle");
  chk_cmd_released: assert property ((|cmd_ff) |-> btn_n)
    else $error("command issued while the button is held");
  chk_del_led: assert property (cmd_ff.del[0] |-> ##[0:3] !led_green_ff[0])
    else $error("online lamp stays lit after delete");
  chk_erase_dflt: assert property (cmd_ff.erase |-> ##[0:3] (range_ff == RNG_B && !angle_ff))
    else $error("erase does not restore the factory range");
  chk_range_quiet: assert property ($changed(range_ff) |-> btn_n)
    else $error("range changed while the button is held");
endmodule

bind bmc_menu bmc_menu_sva bmc_menu_sva_i (.core_clk(core_clk), .rstn(rstn), .btn_n(btn_n),
  .chan(chan), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
  .irq_ff(irq_ff), .led_green_ff(led_green_ff), .led_yellow_ff(led_yellow_ff),
  .cmd_ff(cmd_ff), .range_ff(range_ff), .voltage_ff(voltage_ff), .angle_ff(angle_ff));

// [bmc_menu_tb.sv]
// ----------------------------------------------------------------------
// Self-checking bench for the button menu controller
// ----------------------------------------------------------------------
module bmc_menu_tb
  import bmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 20;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic go = 1'h0;
  logic [15:0] hold_cyc = 16'h0;
  logic [11:0] stat = 12'h0;
  logic [12:0] cmd_acc = 13'h0;
  logic btn_n, busy, irq_ff, voltage_ff, angle_ff;
  logic [31:0] rdata_ff, rv;
  logic [3:0] led_green_ff, led_yellow_ff;
  bmc_chan_t chan;
  bmc_cmd_t cmd_ff;
  bmc_range_t range_ff;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  bmc_menu #(.SEC_CYC(SEC), .DEB_CYC(3), .BLINK_CYC(4)) bmc_menu_i (.core_clk(core_clk),
    .rstn(rstn), .btn_n(btn_n), .chan(chan), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff), .irq_ff(irq_ff), .led_green_ff(led_green_ff),
    .led_yellow_ff(led_yellow_ff), .cmd_ff(cmd_ff), .range_ff(range_ff),
    .voltage_ff(voltage_ff), .angle_ff(angle_ff));
  bmc_menu_op bmc_menu_op_i (.core_clk(core_clk), .rstn(rstn), .go(go), .hold_cyc(hold_cyc),
    .stat(stat), .cmd(cmd_ff), .btn_n(btn_n), .busy(busy), .chan(chan));

  // Clock, command collector and a ceiling well above the planned run.
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (|cmd_ff)
      cmd_acc <= cmd_acc | cmd_ff;
    if (cyc == 12000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("TB: compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'h0;
  endtask

  // Read data are taken in the single cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'h0;
    #1 d = rdata_ff;
  endtask

  // Holding aims 16 of the SEC cycles into a second so debounce slack cannot shift the slot.
  task automatic press(input int sec);
    @(posedge core_clk);
    go <= 1'h1;
    hold_cyc <= 16'(sec * SEC + 16);
    cmd_acc <= 13'h0;
    @(posedge core_clk);
    go <= 1'h0;
  endtask

  task automatic settle();
    int n;
    n = 0;
    @(posedge core_clk);
    while (busy !== 1'h0 && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (20) @(posedge core_clk);
  endtask

  task automatic sel(input int sec);
    press(sec);
    settle();
  endtask

  task automatic look(output logic [1:0] s);
    s = 2'h0;
    repeat (24)
    begin
      @(posedge core_clk);
      #1 s = s | {led_green_ff[0], ~led_green_ff[0]};
    end
  endtask

  task automatic t_erase();
    sel(57);
    chk(32'(cmd_acc), 32'h1);
    rd_reg(8'h04, rv);
    chk(rv, 32'h1);
    chk(32'({range_ff, voltage_ff}), 32'h2);
    wr_reg(8'h0c, 32'h7);
  endtask

  task automatic t_register();
    sel(4);
    chk(32'(cmd_acc), 32'h200);
    rd_reg(8'h04, rv);
    chk(rv, 32'h11);
    rd_reg(8'h0c, rv);
    chk(rv, 32'h5);
    chk(32'(irq_ff), 32'h0);
    wr_reg(8'h10, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq_ff), 32'h1);
    wr_reg(8'h0c, 32'h7);
    repeat (2) @(posedge core_clk);
    chk(32'(irq_ff), 32'h0);
    rd_reg(8'h0c, rv);
    chk(rv, 32'h0);
    wr_reg(8'h20, 32'hff);
    rd_reg(8'h20, rv);
    chk(rv, 32'h0);
    wr_reg(8'h08, 32'h1);
    rd_reg(8'h08, rv);
    chk(rv, 32'h1);
    sel(4);
    chk(32'(cmd_acc), 32'h0);
    wr_reg(8'h08, 32'h0);
  endtask

  task automatic t_blink();
    logic [1:0] s;
    @(posedge core_clk);
    stat <= 12'h011;
    look(s);
    chk(32'(s), 32'h3);
    chk(32'(led_yellow_ff), 32'h1);
    @(posedge core_clk);
    stat <= 12'h000;
    repeat (4) @(posedge core_clk);
    look(s);
    chk(32'(s), 32'h2);
    chk(32'(led_yellow_ff), 32'h0);
  endtask

  task automatic t_range();
    press(38);
    repeat (680) @(posedge core_clk);
    repeat (20)
    begin
      @(posedge core_clk);
      #1 chk(32'(led_green_ff), 32'hf);
    end
    settle();
    chk(32'({range_ff, voltage_ff}), 32'h5);
    rd_reg(8'h04, rv);
    chk(rv, 32'h16);
  endtask

  task automatic t_powercut();
    @(posedge core_clk);
    rstn <= 1'h0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (5) @(posedge core_clk);
    rd_reg(8'h04, rv);
    chk(rv, 32'h16);
    chk(32'({range_ff, voltage_ff}), 32'h5);
  endtask

  task automatic t_delete();
    sel(17);
    chk(32'(cmd_acc), 32'h20);
    chk(32'(led_green_ff[0]), 32'h0);
    rd_reg(8'h04, rv);
    chk(rv, 32'h6);
  endtask

  task automatic t_end();
    wr_reg(8'h0c, 32'h7);
    sel(72);
    chk(32'(cmd_acc), 32'h0);
    rd_reg(8'h04, rv);
    chk(rv, 32'h6);
    rd_reg(8'h0c, rv);
    chk(rv, 32'h2);
  endtask

  // Main sequence: erase first, since the store powers up with unknown contents.
  initial
  begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge core_clk);
    t_erase();
    t_register();
    t_blink();
    t_range();
    t_powercut();
    t_delete();
    t_end();
    close_out();
  end
endmodule

// [bmc_pkg.sv]
package bmc_pkg;

  // Signal ranges; B is the current range, the others are voltage ranges.
  typedef enum logic [1:0] {RNG_A = 2'h0, RNG_B = 2'h1, RNG_C = 2'h2, RNG_D = 2'h3} bmc_range_t;

  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_REG = 4'h1, FN_DEL = 4'h2, FN_RNG = 4'h3,
    FN_CAL = 4'h4, FN_ERASE = 4'h5, FN_ANGLE = 4'h6, FN_SPARE = 4'h7, FN_END = 4'h8
  } bmc_fn_t;

  // Gray codes along load, load, idle, hold, end.
  typedef enum logic [2:0] {
    ST_LOAD0 = 3'h0, ST_LOAD1 = 3'h1, ST_IDLE = 3'h3, ST_HOLD = 3'h2, ST_END = 3'h6
  } bmc_state_t;

  typedef struct packed {
    bmc_fn_t fn;
    logic [1:0] ch;
    bmc_range_t rng;
  } bmc_slot_t;

  // Per-channel status from the radio side, same clock.
  typedef struct packed {
    logic [3:0] sleep;
    logic [3:0] lost;
    logic [3:0] low_batt;
    logic [3:0] reg_done;
  } bmc_chan_t;

  // One-cycle requests to the radio and calibration logic.
  typedef struct packed {
    logic [3:0] reg_start;
    logic [3:0] del;
    logic [3:0] cal;
    logic erase;
  } bmc_cmd_t;

  typedef struct packed {
    bmc_range_t rng;
    logic angle;
    logic [3:0] online;
  } bmc_cfg_t;

endpackage

// [bmc_store.sv]
// Settings memory. Its contents carry no reset, so a power-cycle of the
// controller (rstn) leaves the stored words in place.
module bmc_store
  import bmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_ff
);

  logic [7:0] mem [0:1];

  // ----------------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------------
  // Array stays unreset on purpose so settings survive a reset.
  always_ff @(posedge core_clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Registered read port
  // ----------------------------------------------------------------------
  // Read data appear one cycle after the address.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= mem[addr];
    end
  end

endmodule
